// *** fcp_map.svh ***
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

// Register offsets on the byte-wide register port
`define FCP_PERIOD_HIGH_OFS   8'hD1
`define FCP_DUTY0_HIGH_OFS    8'hD2
`define FCP_DUTY1_HIGH_OFS    8'hD3
`define FCP_DUTY2_HIGH_OFS    8'hD5
`define FCP_DUTY3_HIGH_OFS    8'hD6
`define FCP_PERIOD_LOW_OFS    8'hD9
`define FCP_DUTY0_LOW_OFS     8'hDA
`define FCP_DUTY1_LOW_OFS     8'hDB
`define FCP_MAIN_CTRL_OFS     8'hDC
`define FCP_DUTY2_LOW_OFS     8'hDD
`define FCP_DUTY3_LOW_OFS     8'hDE
`define FCP_PRESCALE_OFS      8'hDF

// Main control register fields
`define FCP_CTRL_RUN_BIT      7
`define FCP_CTRL_LOAD_BIT     6
`define FCP_CTRL_UNDER_BIT    5
`define FCP_CTRL_CLEAR_BIT    4

// Reset values and the all-ones duty code
`define FCP_REG_RESET         8'h00
`define FCP_PRESCALE_RESET    8'h00
`define FCP_DUTY_ALL_ONES     10'h3FF
`define FCP_OUT_RESET         4'hF

`endif

// *** fcp_pkg.sv ***
package fcp_pkg;
    // Period and four duty values for one double-buffered set
    typedef struct packed {
        logic [9:0] period;
        logic [9:0] duty0;
        logic [9:0] duty1;
        logic [9:0] duty2;
        logic [9:0] duty3;
    } fcp_wave_t;

    // Port bit routing of the four channels
    typedef struct packed {
        logic p0_1;
        logic p1_6;
        logic p1_7;
        logic p0_0;
    } fcp_pins_t;

    typedef enum logic [0:0] {
        FCP_IDLE,
        FCP_RUN
    } fcp_state_t;
endpackage

// *** fcp_port_model.sv ***
`timescale 1ns/1ps

// Port latch in front of each channel pin: the pin only follows the
// modulator while the latch bit holds one, as on a quasi-bidirectional port
module fcp_port_model
    import fcp_pkg::*;
(
    input  fcp_pins_t        pins,
    input  wire logic [3:0]  port_latch,
    output logic [3:0]       pin_level
);
    // ----------------------------------------
    // Pin level per channel
    // ----------------------------------------
    // Channel order 0..3 maps to the four routed port bits
    assign pin_level = {pins.p0_0 & port_latch[3],
                        pins.p1_7 & port_latch[2],
                        pins.p1_6 & port_latch[1],
                        pins.p0_1 & port_latch[0]};
endmodule

// *** fcp_prescaler.sv ***
`timescale 1ns/1ps
`include "fcp_map.svh"

// Divides the system clock by (ratio + 1) into a one-cycle tick
module fcp_prescaler
    import fcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic [7:0] ratio,
    output logic            tick
);
    logic [7:0] count;

    // Count down; tick on the terminal count, restart while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
        end else if (!enable || count == 8'h00) begin
            count <= ratio;
        end else begin
            count <= count - 8'h01;
        end
    end

    assign tick = enable && (count == 8'h00);

    // A disabled prescaler never ticks
    property p_no_tick_idle;
        @(posedge clk) disable iff (!rst_n) !enable |-> !tick;
    endproperty
    a_no_tick_idle: assert property (p_no_tick_idle) // [RULE3]
        else $error("prescaler ticked while disabled");
endmodule

// *** fcp_pwm.sv ***
`timescale 1ns/1ps
`include "fcp_map.svh"

// Overview of operation
// RULE1 - Internal channel outputs are one after reset
// RULE2 - One shared 10-bit down counter, prescaled
// RULE3 - Counter clock is system clock over ratio (the prescaler divides by ratio+1)
// RULE4 - Repetition rate is counter clock over period+1
// RULE5 - Duty fraction is duty over period+1
// RULE6 - Period split: low bits 7-0, high 9-8
// RULE7 - Duty split: low bits 7-0, high 9-8
// RULE8 - Clear bit forces counter to zero
// RULE9 - Writing run bit one starts counter
// RULE10 - Output high until counter below duty
// RULE11 - Output low until next underflow
// RULE12 - Underflow reloads counter from period value
// RULE13 - Period and duty registers double buffered
// RULE14 - Transfer only with load pending at underflow
// RULE15 - Channels routed to P0.1, P1.6, P1.7, P0.0
// RULE16 - Software sets port latch bits to one
// RULE17 - Duty all zeroes keeps output high
// RULE18 - Duty all ones keeps output low
// RULE19 - Load bit clears the cycle after transfer
// RULE20 - Per-channel invert bit flips the output
// RULE21 - Prescaler ratio held as separate setting
module fcp_pwm
    import fcp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    output fcp_pins_t       pins,
    output logic [3:0]      channel_out
);
    //----------------------------------------------------------------
    // Storage
    //----------------------------------------------------------------
    fcp_wave_t  buffered;           // Software-visible holding copy
    fcp_wave_t  working;            // Copy the comparators use
    logic [9:0] counter;
    logic       run;
    logic       load_req;
    logic       underflow_flag;
    logic       clear_req;
    logic [3:0] invert;
    logic [7:0] prescale;
    logic [3:0] raw_out;
    logic       transfer_done;
    logic       tick;
    logic       underflow;
    fcp_state_t state;

    // Register writes to a given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = wr_en && (a == ofs);
    endfunction

    // Merge a byte write into one half of a 10-bit value
    function automatic logic [9:0] merge(input logic [9:0] old, input logic [7:0] d,
                                         input logic high);
        merge = high ? {d[1:0], old[7:0]} : {old[9:8], d};
    endfunction

    //----------------------------------------------------------------
    // Holding registers
    //----------------------------------------------------------------
    // Writes land only in the holding copy, never the running waveform
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buffered <= '0;
        end else begin
            if (hit(addr, `FCP_PERIOD_LOW_OFS)) begin
                buffered.period <= merge(buffered.period, wdata, 1'b0);  // [RULE6] [RULE13]
            end
            if (hit(addr, `FCP_PERIOD_HIGH_OFS)) begin
                buffered.period <= merge(buffered.period, wdata, 1'b1);  // [RULE6]
            end
            if (hit(addr, `FCP_DUTY0_LOW_OFS)) begin
                buffered.duty0 <= merge(buffered.duty0, wdata, 1'b0);  // [RULE7]
            end
            if (hit(addr, `FCP_DUTY0_HIGH_OFS)) begin
                buffered.duty0 <= merge(buffered.duty0, wdata, 1'b1);  // [RULE7]
            end
            if (hit(addr, `FCP_DUTY1_LOW_OFS)) begin
                buffered.duty1 <= merge(buffered.duty1, wdata, 1'b0);
            end
            if (hit(addr, `FCP_DUTY1_HIGH_OFS)) begin
                buffered.duty1 <= merge(buffered.duty1, wdata, 1'b1);
            end
            if (hit(addr, `FCP_DUTY2_LOW_OFS)) begin
                buffered.duty2 <= merge(buffered.duty2, wdata, 1'b0);
            end
            if (hit(addr, `FCP_DUTY2_HIGH_OFS)) begin
                buffered.duty2 <= merge(buffered.duty2, wdata, 1'b1);
            end
            if (hit(addr, `FCP_DUTY3_LOW_OFS)) begin
                buffered.duty3 <= merge(buffered.duty3, wdata, 1'b0);
            end
            if (hit(addr, `FCP_DUTY3_HIGH_OFS)) begin
                buffered.duty3 <= merge(buffered.duty3, wdata, 1'b1);
            end
        end
    end

    //----------------------------------------------------------------
    // Control register
    //----------------------------------------------------------------
    // Transfer pulse clears load; a fresh write of load in that cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run            <= 1'b0;
            load_req       <= 1'b0;
            underflow_flag <= 1'b0;
            clear_req      <= 1'b0;
            invert         <= 4'h0;
        end else begin
            clear_req <= 1'b0;
            if (transfer_done) begin
                load_req       <= 1'b0;  // [RULE19]
                underflow_flag <= 1'b0;
            end
            if (hit(addr, `FCP_MAIN_CTRL_OFS)) begin
                run            <= wdata[`FCP_CTRL_RUN_BIT];  // [RULE9]
                load_req       <= wdata[`FCP_CTRL_LOAD_BIT];
                underflow_flag <= wdata[`FCP_CTRL_UNDER_BIT];
                clear_req      <= wdata[`FCP_CTRL_CLEAR_BIT];  // [RULE8]
                invert         <= wdata[3:0];
            end
            // Hardware set comes last so a racing software clear cannot hide it
            if (underflow && run && load_req) begin
                underflow_flag <= 1'b1;
            end
        end
    end

    // Prescaler ratio held apart from the main control bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= `FCP_PRESCALE_RESET;
        end else if (hit(addr, `FCP_PRESCALE_OFS)) begin
            prescale <= wdata;  // [RULE21]
        end
    end

    //----------------------------------------------------------------
    // Counter
    //----------------------------------------------------------------
    fcp_prescaler u_prescaler (
        .clk    (clk),
        .rst_n  (rst_n),
        .enable (run),
        .ratio  (prescale),
        .tick   (tick)
    );

    // Underflow is the tick that finds the counter already at zero
    assign underflow = tick && (counter == 10'h000);

    // Run state tracks the run bit, used for idle-hold of outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FCP_IDLE;
        end else begin
            case (state)
                FCP_IDLE: state <= run ? FCP_RUN : FCP_IDLE;
                FCP_RUN:  state <= run ? FCP_RUN : FCP_IDLE;
                default:  state <= FCP_IDLE;
            endcase
        end
    end

    // One down counter for all channels, reloaded on underflow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter <= 10'h000;
        end else if (clear_req) begin
            counter <= 10'h000;  // [RULE8]
        end else if (underflow) begin
            counter <= (load_req ? buffered.period : working.period);  // [RULE12] [RULE4]
        end else if (tick) begin
            counter <= counter - 10'h001;  // [RULE2] [RULE3]
        end
    end

    // Working copy changes only at a period boundary with load pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working       <= '0;
            transfer_done <= 1'b0;
        end else begin
            transfer_done <= 1'b0;
            if (underflow && load_req) begin
                working       <= buffered;  // [RULE14]
                transfer_done <= 1'b1;
            end
        end
    end

    //----------------------------------------------------------------
    // Compare and output
    //----------------------------------------------------------------
    // One compare: high while counter >= duty, duty 0 always high, all ones always low
    function automatic logic level(input logic [9:0] cnt, input logic [9:0] duty);
        if (duty == 10'h000) begin
            level = 1'b1;  // [RULE17]
        end else if (duty == `FCP_DUTY_ALL_ONES) begin
            level = 1'b0;  // [RULE18]
        end else begin
            level = !(cnt < duty);  // [RULE10] [RULE11]
        end
    endfunction

    // Raw compare outputs hold their last level while stopped, as software expects; channel_out still follows invert
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_out <= `FCP_OUT_RESET;  // [RULE1]
        end else if (state == FCP_RUN) begin
            raw_out[0] <= level(counter, working.duty0);  // [RULE5]
            raw_out[1] <= level(counter, working.duty1);
            raw_out[2] <= level(counter, working.duty2);
            raw_out[3] <= level(counter, working.duty3);
        end
    end

    // Invert after compare; high before drop, low after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_out <= `FCP_OUT_RESET;  // [RULE1]
        end else begin
            channel_out <= raw_out ^ invert;  // [RULE20]
        end
    end

    // Port routing; the latch bit of each pin must be one outside this block
    assign pins.p0_1 = channel_out[0];  // [RULE15] [RULE16]
    assign pins.p1_6 = channel_out[1];
    assign pins.p1_7 = channel_out[2];
    assign pins.p0_0 = channel_out[3];

    //----------------------------------------------------------------
    // Read port
    //----------------------------------------------------------------
    // Data valid the cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `FCP_PERIOD_LOW_OFS:  rdata <= buffered.period[7:0];
                `FCP_PERIOD_HIGH_OFS: rdata <= {6'h00, buffered.period[9:8]};
                `FCP_DUTY0_LOW_OFS:   rdata <= buffered.duty0[7:0];
                `FCP_DUTY0_HIGH_OFS:  rdata <= {6'h00, buffered.duty0[9:8]};
                `FCP_DUTY1_LOW_OFS:   rdata <= buffered.duty1[7:0];
                `FCP_DUTY1_HIGH_OFS:  rdata <= {6'h00, buffered.duty1[9:8]};
                `FCP_DUTY2_LOW_OFS:   rdata <= buffered.duty2[7:0];
                `FCP_DUTY2_HIGH_OFS:  rdata <= {6'h00, buffered.duty2[9:8]};
                `FCP_DUTY3_LOW_OFS:   rdata <= buffered.duty3[7:0];
                `FCP_DUTY3_HIGH_OFS:  rdata <= {6'h00, buffered.duty3[9:8]};
                `FCP_MAIN_CTRL_OFS:   rdata <= {run, load_req, underflow_flag, 1'b0, invert};
                `FCP_PRESCALE_OFS:    rdata <= prescale;
                default:              rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    sequence s_transfer;
        underflow && load_req;
    endsequence

    property p_reload;
        @(posedge clk) disable iff (!rst_n)
            underflow && !clear_req |=>
                counter == $past(working.period) || counter == $past(buffered.period);
    endproperty
    a_reload: assert property (p_reload) // [RULE12]
        else $error("counter not reloaded on underflow");

    property p_load_clear;
        @(posedge clk) disable iff (!rst_n)
            s_transfer ##1 !(wr_en && addr == `FCP_MAIN_CTRL_OFS) |=> !load_req;
    endproperty
    a_load_clear: assert property (p_load_clear) // [RULE19]
        else $error("load bit not cleared after transfer");

    property p_transfer;
        @(posedge clk) disable iff (!rst_n) s_transfer |=> working == $past(buffered);
    endproperty
    a_transfer: assert property (p_transfer) // [RULE14]
        else $error("buffered values not transferred");

    property p_hold_working;
        @(posedge clk) disable iff (!rst_n) !(underflow && load_req) |=> $stable(working);
    endproperty
    a_hold_working: assert property (p_hold_working) // [RULE13]
        else $error("working values changed without transfer");

    property p_clear;
        @(posedge clk) disable iff (!rst_n) clear_req |=> counter == 10'h000;
    endproperty
    a_clear: assert property (p_clear) // [RULE8]
        else $error("clear did not zero counter");

    property p_stopped;
        @(posedge clk) disable iff (!rst_n) !run && !clear_req |=> $stable(counter);
    endproperty
    a_stopped: assert property (p_stopped) // [RULE9]
        else $error("counter moved while stopped");

    property p_zero_duty;
        @(posedge clk) disable iff (!rst_n)
            state == FCP_RUN && working.duty0 == 10'h000 |=> raw_out[0];
    endproperty
    a_zero_duty: assert property (p_zero_duty) // [RULE17]
        else $error("zero duty not high");

    property p_full_duty;
        @(posedge clk) disable iff (!rst_n)
            state == FCP_RUN && working.duty1 == `FCP_DUTY_ALL_ONES |=> !raw_out[1];
    endproperty
    a_full_duty: assert property (p_full_duty) // [RULE18]
        else $error("full duty not low");

    property p_invert;
        @(posedge clk) disable iff (!rst_n)
            1'b1 |=> channel_out == ($past(raw_out) ^ $past(invert));
    endproperty
    a_invert: assert property (p_invert) // [RULE20]
        else $error("invert not applied");

    // Once below its duty a channel stays low until the counter reloads
    property p_stay_low;
        @(posedge clk) disable iff (!rst_n)
            state == FCP_RUN && !raw_out[2] && !$past(underflow) |=> !raw_out[2];
    endproperty
    a_stay_low: assert property (p_stay_low) // [RULE11]
        else $error("channel rose before underflow");

    // The underflow flag drops with the load bit unless set again or written
    property p_flag_clear;
        @(posedge clk) disable iff (!rst_n)
            transfer_done && !underflow && !(wr_en && addr == `FCP_MAIN_CTRL_OFS)
                |=> !underflow_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // [RULE19]
        else $error("underflow flag not cleared after transfer");
endmodule

// *** fcp_pwm_tb_top.sv ***
`timescale 1ns/1ps
`include "fcp_map.svh"

module fcp_pwm_tb_top import fcp_pkg::*;;
    logic        clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rdata;
    fcp_pins_t   pins;
    logic [3:0]  channel_out;
    logic [3:0]  port_latch;
    logic [3:0]  pin_level;
    int          err_total;
    int          checks_done;
    int          cyc;
    int          lows [4];
    logic [9:0]  duty_cfg [4] = '{10'h000, 10'h3FF, 10'h004, 10'h003};
    logic [3:0]  inv_cfg = 4'h8;
    logic [7:0]  ofs [10] = '{`FCP_PERIOD_LOW_OFS, `FCP_PERIOD_HIGH_OFS, `FCP_DUTY0_LOW_OFS,
        `FCP_DUTY0_HIGH_OFS, `FCP_DUTY1_LOW_OFS, `FCP_DUTY1_HIGH_OFS, `FCP_DUTY2_LOW_OFS,
        `FCP_DUTY2_HIGH_OFS, `FCP_DUTY3_LOW_OFS, `FCP_DUTY3_HIGH_OFS};
    logic [7:0]  val [10] = '{8'h09, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h03, 8'h04, 8'h00, 8'h03, 8'h00};

    fcp_pwm u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
                   .rd_en(rd_en), .rdata(rdata), .pins(pins), .channel_out(channel_out));
    fcp_port_model u_port (.pins(pins), .port_latch(port_latch), .pin_level(pin_level));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Low-level count per channel over a whole number of periods
    function automatic int exp_low(input logic [9:0] d, input int p, input logic inv);
        int lo;
        lo = (d == 10'h000) ? 0 : ((d == 10'h3FF) ? p + 1 : int'(d));
        if (inv)
            lo = p + 1 - lo;
        return lo;
    endfunction

    task automatic judge_wave(input int p, input int div, input int nper);
        int i;
        int c;
        for (c = 0; c < 4; c++)
            lows[c] = 0;
        for (i = 0; i < nper * (p + 1) * div; i++) begin
            @(negedge clk);
            for (c = 0; c < 4; c++)
                lows[c] += (channel_out[c] === 1'b0) ? 1 : 0;
            chk({12'h000, pin_level}, {12'h000, channel_out});
        end
        chk(lows[0], exp_low(duty_cfg[0], p, inv_cfg[0]) * nper * div);
        chk(lows[1], exp_low(duty_cfg[1], p, inv_cfg[1]) * nper * div);
        chk(lows[2], exp_low(duty_cfg[2], p, inv_cfg[2]) * nper * div);
        chk(lows[3], exp_low(duty_cfg[3], p, inv_cfg[3]) * nper * div);
    endtask

    // Poll until the pending transfer has been taken
    task automatic wait_load();
        logic [7:0] v = 8'hFF;
        int         n = 0;
        while (v[`FCP_CTRL_LOAD_BIT] !== 1'b0 && n < 200) begin
            rd(`FCP_MAIN_CTRL_OFS, v);
            n++;
        end
        chk(v[`FCP_CTRL_LOAD_BIT], 1'b0);
        chk(v[`FCP_CTRL_CLEAR_BIT], 1'b0);
        chk(v[`FCP_CTRL_UNDER_BIT], 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset for three edges, then everything reads back at its reset value
    task automatic t_reset();
        logic [7:0] v;
        int         i;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({12'h000, channel_out}, {12'h000, `FCP_OUT_RESET});
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({12'h000, channel_out}, {12'h000, `FCP_OUT_RESET});
        chk({12'h000, pins}, {12'h000, `FCP_OUT_RESET});
        for (i = 0; i < 10; i++) begin
            rd(ofs[i], v);
            chk(v, `FCP_REG_RESET);
        end
        rd(`FCP_MAIN_CTRL_OFS, v);
        chk(v, `FCP_REG_RESET);
        rd(`FCP_PRESCALE_OFS, v);
        chk(v, `FCP_PRESCALE_RESET);
    endtask

    // Writes land in both halves; an unmapped write is ignored
    task automatic t_regs();
        logic [7:0] v;
        int         i;
        for (i = 0; i < 10; i++)
            wr(ofs[i], val[i]);
        wr(8'hD0, 8'h5A);
        for (i = 0; i < 10; i++) begin
            rd(ofs[i], v);
            chk(v, val[i]);
        end
        rd(8'hD0, v);
        chk(v, 8'h00);
    endtask

    // Idle outputs stay high until run; then load, run, invert channel 3
    task automatic t_start();
        wr(`FCP_MAIN_CTRL_OFS, 8'h10);
        repeat (5) @(negedge clk);
        chk({12'h000, channel_out}, {12'h000, `FCP_OUT_RESET});
        wr(`FCP_MAIN_CTRL_OFS, 8'hC8);
        wait_load();
        repeat (25) @(posedge clk);
        judge_wave(9, 1, 3);
    endtask

    task automatic t_prescale();
        wr(`FCP_PRESCALE_OFS, 8'h01);
        repeat (45) @(posedge clk);
        judge_wave(9, 2, 3);
    endtask

    // Buffered period is ignored until load is set and the period ends
    task automatic t_reload();
        wr(`FCP_PERIOD_LOW_OFS, 8'h04);
        repeat (45) @(posedge clk);
        judge_wave(9, 2, 2);
        wr(`FCP_MAIN_CTRL_OFS, 8'hC8);
        wait_load();
        repeat (25) @(posedge clk);
        judge_wave(4, 2, 3);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n       = 1'b0;
        addr        = 8'h00;
        wdata       = 8'h00;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        port_latch  = 4'hF;
        err_total   = 0;
        checks_done = 0;
        cyc         = 0;
        t_reset();
        t_regs();
        t_start();
        t_prescale();
        t_reload();
        t_reset();
        end_sim();
    end
endmodule
